// ---- asw_defines.vh ----
`ifndef ASW_DEFINES_VH
`define ASW_DEFINES_VH
`define ASW_WORD_BITS      24
`define ASW_IN_BITS        16
`define ASW_CNT_W          5
`define ASW_LAST_BIT       5'd24
`define ASW_IN_LAST        5'd16
`define ASW_RES_W          17
`define ASW_PAD_ZERO       4'h0
`define ASW_PRE_KEEP0      3'h0
`define ASW_PRE_KEEP1      3'h4
`define ASW_PRE_LOAD       3'h5
`define ASW_RST_CHAN       5'h00
`define ASW_RST_REJECT     2'h0
`define ASW_RST_GAIN       3'h0
`define ASW_RES_POS_OVER   17'h10000
`define ASW_RES_NEG_UNDER  17'h1ffff
`define ASW_FIFO_DEPTH     32
`define ASW_FIFO_AW        5
`endif

// ---- asw_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module asw_host (
  // Clock and answer line.
  input  wire logic ref_clk_in,
  input  wire logic serial_out_in,
  // Serial pins towards the device.
  output var logic  serial_clk_out,
  output var logic  chip_select_n_out,
  output var logic  serial_data_out
);
  initial
  begin
    serial_clk_out = 1'b0;
    chip_select_n_out = 1'b1;
    serial_data_out = 1'b0;
  end
  // Half a serial period is 80 ns, so the device sees each level for 8 cycles.
  task automatic half();
    repeat (8) @(posedge ref_clk_in);
  endtask
  // Pulses n clocks; with sel low the device stays deselected.
  task automatic xfer(input logic [15:0] din, input int n, input logic sel,
                      output logic [23:0] dout);
    dout = 24'h0;
    chip_select_n_out <= !sel;
    half();
    for (int i = 0; i < n; i++)
    begin
      serial_data_out <= (i < 16) ? din[15 - i] : ~serial_data_out;
      half();
      serial_clk_out <= 1'b1;
      dout[23 - i] = serial_out_in;
      half();
      serial_clk_out <= 1'b0;
    end
    half();
    chip_select_n_out <= 1'b1;
    half();
  endtask
endmodule
`default_nettype wire

// ---- asw_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module asw_monitor (
  // Clock, reset and serial pins.
  input wire logic       ref_clk_in,
  input wire logic       reset_in,
  input wire logic       serial_clk_in,
  input wire logic       chip_select_n_in,
  input wire logic       serial_out_out,
  input wire logic       serial_out_oe_out,
  // Conversion control and settings.
  input wire logic       conv_start_out,
  input wire logic       converting_out,
  input wire logic       temp_sensor_select_out,
  input wire logic       rate_double_out,
  input wire logic [2:0] gain_code_out,
  input wire logic [3:0] channel_addr_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  // ********
  // Checks
  // ********
  // The select pin is synchronised, so a few cycles of lag are allowed.
  AST_OE_OFF: assert property (chip_select_n_in [*4] |-> !serial_out_oe_out)
    else $error("output driven while deselected");
  AST_OE_ON: assert property (!chip_select_n_in [*4] |-> serial_out_oe_out)
    else $error("output not driven while selected");
  AST_DONE_FLAG: assert property ($fell(chip_select_n_in) ##1
    (!chip_select_n_in && !serial_clk_in && $stable(converting_out)) [*6]
    |-> serial_out_out == converting_out)
    else $error("done flag wrong");
  AST_START_PULSE: assert property (conv_start_out |=> !conv_start_out)
    else $error("start longer than one cycle");
  AST_CONV_RISE: assert property (conv_start_out |=> converting_out)
    else $error("start without conversion");
  AST_RESET_CFG: assert property ($fell(reset_in) |-> gain_code_out == 3'h0
    && channel_addr_out == 4'h0 && !temp_sensor_select_out ##[0:2] conv_start_out)
    else $error("bad state after reset");
  AST_CFG_HOLD: assert property ($changed({channel_addr_out, gain_code_out, rate_double_out,
    temp_sensor_select_out}) |-> conv_start_out || $past(conv_start_out))
    else $error("settings changed outside a start");
  AST_TEMP_RATE: assert property (temp_sensor_select_out |-> !rate_double_out)
    else $error("double rate with sensor");
endmodule
`default_nettype wire

// ---- asw_port.v ----
`timescale 1ns/1ps
`default_nettype none
`include "asw_defines.vh"

module asw_fifo #(
  parameter WIDTH = 17,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  input  wire             ref_clk_in,
  input  wire             reset_in,
  input  wire             in_valid_in,
  output wire             in_ready_out,
  input  wire [WIDTH-1:0] in_data_in,
  output wire             out_valid_out,
  input  wire             out_ready_in,
  output wire [WIDTH-1:0] out_data_out
);
  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [AW:0]      wr_r;
  reg [AW:0]      rd_r;
  wire            full;
  wire            empty;
  assign empty         = (wr_r == rd_r);
  assign full          = (wr_r[AW-1:0] == rd_r[AW-1:0]) && (wr_r[AW] != rd_r[AW]);
  assign in_ready_out  = !full;
  assign out_valid_out = !empty;
  assign out_data_out  = mem_r[rd_r[AW-1:0]];
  always @(posedge ref_clk_in)
  begin
    if (in_valid_in && !full)
    begin
      mem_r[wr_r[AW-1:0]] <= in_data_in;
    end
  end
  always @(posedge ref_clk_in)
  begin
    if (reset_in)
    begin
      wr_r <= {(AW+1){1'b0}};
      rd_r <= {(AW+1){1'b0}};
    end
    else
    begin
      if (in_valid_in && !full)
      begin
        wr_r <= wr_r + 1'b1;
      end
      if (out_ready_in && !empty)
      begin
        rd_r <= rd_r + 1'b1;
      end
    end
  end
endmodule

module asw_port (
  // Clock and reset.
  input  wire                   ref_clk_in,
  input  wire                   reset_in,
  // Serial pins.
  input  wire                   serial_clk_in,
  input  wire                   chip_select_n_in,
  input  wire                   serial_in_in,
  output reg                    serial_out_out,
  output reg                    serial_out_oe_out,
  // Converter result stream.
  input  wire                   result_valid_in,
  output wire                   result_ready_out,
  input  wire [`ASW_RES_W-1:0]  result_in,
  input  wire                   over_range_in,
  input  wire                   under_range_in,
  // Conversion control and configuration.
  output reg                    conv_start_out,
  output reg                    single_ended_select_out,
  output reg [3:0]              channel_addr_out,
  output reg                    temp_sensor_select_out,
  output reg                    reject_freq_hi_out,
  output reg                    reject_freq_lo_out,
  output reg                    rate_double_out,
  output reg [2:0]              gain_code_out,
  output reg                    converting_out
);
  // ********************************
  // Pin synchronisers and edge detect.
  // ********************************
  reg  [1:0] sck_s_r;
  reg  [1:0] cs_s_r;
  reg  [1:0] sdi_s_r;
  reg        sck_d_r;
  wire       sel;
  wire       rise;
  wire       fall;
  always @(posedge ref_clk_in)
  begin
    if (reset_in)
    begin
      sck_s_r <= 2'h0;
      cs_s_r  <= 2'h3;
      sdi_s_r <= 2'h0;
      sck_d_r <= 1'b0;
    end
    else
    begin
      sck_s_r <= {sck_s_r[0], serial_clk_in};
      cs_s_r  <= {cs_s_r[0], chip_select_n_in};
      sdi_s_r <= {sdi_s_r[0], serial_in_in};
      sck_d_r <= sck_s_r[1];
    end
  end
  assign sel  = !cs_s_r[1];
  assign rise = sel && sck_s_r[1] && !sck_d_r;
  assign fall = sel && !sck_s_r[1] && sck_d_r;

  // ********************************
  // Result buffering and word format.
  // ********************************
  wire                  fifo_valid;
  wire [`ASW_RES_W-1:0] fifo_data;
  wire                  fifo_ovr;
  wire                  fifo_und;
  reg                   fifo_pop;
  asw_fifo #(
    .WIDTH (`ASW_RES_W + 2),
    .DEPTH (`ASW_FIFO_DEPTH),
    .AW    (`ASW_FIFO_AW)
  ) u_fifo (
    .ref_clk_in    (ref_clk_in),
    .reset_in      (reset_in),
    .in_valid_in   (result_valid_in),
    .in_ready_out  (result_ready_out),
    .in_data_in    ({over_range_in, under_range_in, result_in}),
    .out_valid_out (fifo_valid),
    .out_ready_in  (fifo_pop),
    .out_data_out  ({fifo_ovr, fifo_und, fifo_data})
  );
  reg  [`ASW_RES_W-1:0] code;
  always @*
  begin
    // Offset binary: top bit acts as sign, next 16 as magnitude.
    if (fifo_ovr)
    begin
      code = `ASW_RES_POS_OVER;
    end
    else if (fifo_und)
    begin
      code = `ASW_RES_NEG_UNDER;
    end
    else
    begin
      code = fifo_data;
    end
  end
  // Sign followed by result, overrange gives 11, underrange 00.
  wire                      sign_bit;
  wire                      msb_bit;
  wire [`ASW_WORD_BITS-1:0] word;
  assign sign_bit = fifo_ovr | (!fifo_und & code[16]);
  assign msb_bit  = fifo_ovr | (!fifo_und & !code[16]);
  assign word = {1'b0, 1'b0, sign_bit, msb_bit,
                 code[15:0], `ASW_PAD_ZERO};

  // ********************************
  // Transfer state.
  // ********************************
  localparam ST_IDLE = 1'b0;
  localparam ST_XFER = 1'b1;
  reg                       state_r;
  reg [`ASW_CNT_W-1:0]      fall_cnt_r;
  reg [`ASW_CNT_W-1:0]      in_cnt_r;
  reg [`ASW_WORD_BITS-1:0]  shift_r;
  reg [`ASW_IN_BITS-1:0]    in_r;
  reg                       done_r;
  wire                      ready;
  // Field views of the received word, aligned as if all 16 bits arrived.
  wire [`ASW_IN_BITS-1:0]   in_al;
  wire [2:0]                in_r_top3;
  wire                      in_r_sgl;
  wire [3:0]                in_r_addr;
  assign in_al     = in_r << (`ASW_IN_LAST - in_cnt_r);
  assign in_r_top3 = in_al[15:13];
  assign in_r_sgl  = in_al[12];
  assign in_r_addr = in_al[11:8];
  assign ready = fifo_valid;
  always @(posedge ref_clk_in)
  begin
    if (reset_in)
    begin
      state_r                 <= ST_IDLE;
      fall_cnt_r              <= 5'h00;
      in_cnt_r                <= 5'h00;
      shift_r                 <= 24'h000000;
      in_r                    <= 16'h0000;
      done_r                  <= 1'b0;
      fifo_pop                <= 1'b0;
      conv_start_out          <= 1'b1;
      converting_out          <= 1'b1;
      single_ended_select_out <= 1'b0;
      channel_addr_out        <= 4'h0;
      temp_sensor_select_out  <= 1'b0;
      reject_freq_hi_out      <= 1'b0;
      reject_freq_lo_out      <= 1'b0;
      rate_double_out         <= 1'b0;
      gain_code_out           <= `ASW_RST_GAIN;
      serial_out_out          <= 1'b0;
      serial_out_oe_out       <= 1'b0;
    end
    else
    begin
      conv_start_out <= 1'b0;
      fifo_pop       <= 1'b0;
      done_r         <= 1'b0;
      if (ready && !fifo_pop)
      begin
        converting_out <= 1'b0;
      end
      serial_out_oe_out <= sel;
      case (state_r)
        ST_IDLE:
        begin
          // Done flag follows conversion state live while selected.
          serial_out_out <= !ready;
          fall_cnt_r     <= 5'h00;
          in_cnt_r       <= 5'h00;
          if (sel && ready && !fifo_pop)
          begin
            state_r <= ST_XFER;
            shift_r <= word;
          end
        end
        ST_XFER:
        begin
          if (!sel || done_r)
          begin
            state_r <= ST_IDLE;
          end
          else
          begin
            if (rise && in_cnt_r < `ASW_IN_LAST)
            begin
              in_r     <= {in_r[14:0], sdi_s_r[1]};
              in_cnt_r <= in_cnt_r + 5'h01;
            end
            if (fall)
            begin
              shift_r        <= {shift_r[22:0], 1'b0};
              serial_out_out <= shift_r[22];
              fall_cnt_r     <= fall_cnt_r + 5'h01;
            end
          end
          // Word ends on 24th fall or early deselect; start next conversion.
          if ((fall && fall_cnt_r == `ASW_LAST_BIT - 5'h01) ||
              (!sel && in_cnt_r != 5'h00))
          begin
            done_r         <= 1'b1;
            fifo_pop       <= 1'b1;
            conv_start_out <= 1'b1;
            converting_out <= 1'b1;
            // Settings latch only here, so the delivered word is unaffected.
            if (in_cnt_r >= 5'h08 && in_r_top3 == `ASW_PRE_LOAD)
            begin
              single_ended_select_out <= in_r_sgl;
              channel_addr_out        <= in_r_addr;
              if (in_cnt_r == `ASW_IN_LAST && in_r[7])
              begin
                temp_sensor_select_out <= in_r[6];
                reject_freq_hi_out     <= in_r[5];
                reject_freq_lo_out     <= in_r[4];
                // Temperature mode forces 1x and ignores gain.
                rate_double_out <= in_r[6] ? 1'b0 : in_r[3];
                gain_code_out   <= in_r[6] ? `ASW_RST_GAIN : in_r[2:0];
              end
            end
          end
        end
        default:
        begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk, rst, sck, csn, serial_in, serial_out, oe, rv, rr, ov, un, cs_p;
  logic        single_ended_select, tmp, rh, rl, rd, conv;
  logic [16:0] res;
  logic [3:0]  addr;
  logic [2:0]  gain;
  logic [23:0] w;
  logic [11:0] exp_c;
  int          errors, checked, starts, s0;
  logic [15:0] din [6] = '{16'h0000, 16'h8fff, 16'hb6aa, 16'hab7f, 16'ha1da, 16'ha081};
  logic [16:0] rs [6] = '{17'h10000, 17'h0ffff, 17'h1ffff, 17'h0, 17'h0, 17'h0};
  logic [5:0]  ovt = 6'b001000;
  logic [5:0]  unt = 6'b010000;
  asw_port DUT (.ref_clk_in(clk), .reset_in(rst), .serial_clk_in(sck), .chip_select_n_in(csn),
    .serial_in_in(serial_in), .serial_out_out(serial_out), .serial_out_oe_out(oe), .result_valid_in(rv),
    .result_ready_out(rr), .result_in(res), .over_range_in(ov), .under_range_in(un),
    .conv_start_out(cs_p), .single_ended_select_out(single_ended_select), .channel_addr_out(addr),
    .temp_sensor_select_out(tmp), .reject_freq_hi_out(rh), .reject_freq_lo_out(rl),
    .rate_double_out(rd), .gain_code_out(gain), .converting_out(conv));
  asw_host u_host (.ref_clk_in(clk), .serial_out_in(serial_out), .serial_clk_out(sck),
    .chip_select_n_out(csn), .serial_data_out(serial_in));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) if (cs_p === 1'b1) starts <= starts + 1;
  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    checked++;
    if (g !== e)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic push(input logic [16:0] r, input logic o, input logic u);
    @(posedge clk);
    res <= r;
    ov <= o;
    un <= u;
    rv <= 1'b1;
    @(posedge clk);
    while (rr !== 1'b1) @(posedge clk);
    rv <= 1'b0;
  endtask
  function automatic logic [23:0] fmt(logic [16:0] r, logic o, logic u);
    logic [17:0] v;
    v = o ? 18'h30000 : u ? 18'h0ffff : {r[16], ~r[16], r[15:0]};
    return {2'b00, v, 4'h0};
  endfunction
  function automatic logic [11:0] nxt(logic [11:0] c, logic [15:0] d);
    if (d[15:13] != 3'b101) return c;
    c[11:7] = d[12:8];
    if (d[7]) c[6:0] = d[6] ? {d[6:4], 4'h0} : d[6:0];
    return c;
  endfunction
  task automatic test_done();
    if (errors == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial
  begin
    repeat (40000) @(posedge clk);
    errors++;
    test_done();
  end
  initial
  begin
    rst = 1'b1;
    rv = 1'b0;
    res = 17'h0;
    ov = 1'b0;
    un = 1'b0;
    exp_c = 12'h0;
    starts = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    chk("reset config", 24'h0, 24'({single_ended_select, addr, tmp, rh, rl, rd, gain}));
    s0 = starts;
    u_host.xfer(16'hffff, 3, 1'b0, w);
    chk("oe idle", 24'h0, 24'(oe));
    chk("starts idle", 24'(s0), 24'(starts));
    for (int i = 0; i < 6; i++)
    begin
      push(rs[i], ovt[i], unt[i]);
      u_host.xfer(din[i], 24, 1'b1, w);
      chk("word", fmt(rs[i], ovt[i], unt[i]), w);
      exp_c = nxt(exp_c, din[i]);
      repeat (4) @(posedge clk);
      chk("config", 24'(exp_c), 24'({single_ended_select, addr, tmp, rh, rl, rd, gain}));
      u_host.xfer(16'h0, 1, 1'b1, w);
      chk("busy flag", 24'h800000, w);
    end
    // Fill the buffer while the host stalls, then drain it in order.
    for (int i = 0; i < 32; i++) push(17'h10000 + 17'(i * 3), 1'b0, 1'b0);
    @(posedge clk);
    chk("ready when full", 24'h0, 24'(rr));
    for (int i = 0; i < 32; i++)
    begin
      u_host.xfer(16'h0, 24, 1'b1, w);
      chk("drained word", fmt(17'h10000 + 17'(i * 3), 1'b0, 1'b0), w);
    end
    push(17'h1abcd, 1'b0, 1'b0);
    s0 = starts;
    u_host.xfer(16'h0, 5, 1'b1, w);
    chk("abort start", 24'(s0 + 1), 24'(starts));
    test_done();
  end
endmodule
bind asw_port asw_monitor u_mon (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
  .serial_clk_in(serial_clk_in), .chip_select_n_in(chip_select_n_in),
  .serial_out_out(serial_out_out), .serial_out_oe_out(serial_out_oe_out),
  .conv_start_out(conv_start_out), .converting_out(converting_out),
  .temp_sensor_select_out(temp_sensor_select_out), .rate_double_out(rate_double_out),
  .gain_code_out(gain_code_out), .channel_addr_out(channel_addr_out));
`default_nettype wire
